// ---- rtl/clock_divider_control_pkg.sv ----
// Function
// R1: writing one to counter-clear bit zeroes basic timer count; zero does nothing
// R2: writing one to divider-clear bit resets both prescale dividers; zero does nothing (code clears only the timer divider, the cpu divider keeps counting)
// R3: after reset the cpu clock runs at oscillator divided by sixteen
// R4: clock select bits 4:3 give divide by 16, 8, 2, 1 for codes 00..11
// R5: software picks a faster cpu clock by writing bits 4:3
// R6: basic timer select bits 3:2 give divide by 4096, 1024, 128, 16
// R7: both clear bits return to zero by themselves and read back as zero
package clock_divider_control_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] BASIC_TIMER_CONTROL_OFFSET  = 8'hD3;
    localparam logic [7:0] SYSTEM_CLOCK_CONTROL_OFFSET = 8'hD4;
    localparam logic [7:0] BASIC_TIMER_CONTROL_RESET   = 8'h00;
    localparam logic [7:0] SYSTEM_CLOCK_CONTROL_RESET  = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int COUNTER_CLEAR_BIT = 0 + 1;
    localparam int DIVIDER_CLEAR_BIT = 0;
    localparam int TIMER_SEL_LSB     = 2;
    localparam int WATCHDOG_CODE_LSB = 4;
    localparam int CPU_SEL_LSB       = 3;
    localparam int WAKE_DISABLE_BIT  = 7;

    // ------------------------------------------------------------
    // divide codes
    // ------------------------------------------------------------
    localparam logic [1:0] CPU_DIV16 = 2'h0;
    localparam logic [1:0] CPU_DIV8  = 2'h1;
    localparam logic [1:0] CPU_DIV2  = 2'h2;
    localparam logic [1:0] CPU_DIV1  = 2'h3;
    localparam logic [1:0] BT_DIV4096 = 2'h0;
    localparam logic [1:0] BT_DIV1024 = 2'h1;
    localparam logic [1:0] BT_DIV128  = 2'h2;
    localparam logic [1:0] BT_DIV16   = 2'h3;
    localparam int PRESCALE_WIDTH = 12;
    localparam int BT_COUNT_WIDTH = 8;
endpackage

// ---- rtl/prescale_counter.sv ----
`timescale 1ns/1ps
// free-running divider; outputs its raw count, clear resets it
module prescale_counter #(
    parameter int WIDTH = 12
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // control
    input  wire logic             clear,
    // state
    output logic      [WIDTH-1:0] count
);
    // --------------------------------------------------------
    // counter
    // --------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end
endmodule

// ---- rtl/clock_divider_control.sv ----
`timescale 1ns/1ps
module clock_divider_control
    import clock_divider_control_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // clock enables
    output logic             cpuClockEnable,
    output logic             timerClockEnable,
    output logic             counterTick,
    // state
    output logic [7:0]       basicTimerCount,
    output logic [1:0]       cpuSelect,
    output logic             wakeDisable,
    output logic [3:0]       watchdogCode
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // one wait cycle per access: request is answered the cycle after it rises
    logic       ack;
    logic [1:0] timerSelect;
    wire        access   = (read | write) & ~ack;
    wire        hitTimer = (address == BASIC_TIMER_CONTROL_OFFSET);
    wire        hitClock = (address == SYSTEM_CLOCK_CONTROL_OFFSET);
    wire        wrTimer  = write & ack & hitTimer;
    wire        wrClock  = write & ack & hitClock;
    wire        clearCounter = wrTimer & writedata[COUNTER_CLEAR_BIT]; // R1
    wire        clearDivider = wrTimer & writedata[DIVIDER_CLEAR_BIT]; // R2

    assign waitrequest = (read | write) & ~ack;

    // clear bits never stored so they read zero
    wire [7:0]  timerView = {watchdogCode, timerSelect, 2'b00}; // R7
    wire [7:0]  clockView = {wakeDisable, 2'b00, cpuSelect, 3'b000};
    wire [7:0]  readMux   = hitTimer ? timerView : (hitClock ? clockView : 8'h00);

    // ------------------------------------------------------------
    // handshake and read data
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack      <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            ack      <= access;
            readdata <= access ? {24'h00_0000, readMux} : readdata;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpuSelect    <= SYSTEM_CLOCK_CONTROL_RESET[CPU_SEL_LSB +: 2]; // R3
            wakeDisable  <= SYSTEM_CLOCK_CONTROL_RESET[WAKE_DISABLE_BIT];
            timerSelect  <= BASIC_TIMER_CONTROL_RESET[TIMER_SEL_LSB +: 2];
            watchdogCode <= BASIC_TIMER_CONTROL_RESET[WATCHDOG_CODE_LSB +: 4];
        end else begin
            if (wrClock) begin
                cpuSelect   <= writedata[CPU_SEL_LSB +: 2]; // R5
                wakeDisable <= writedata[WAKE_DISABLE_BIT];
            end
            if (wrTimer) begin
                timerSelect  <= writedata[TIMER_SEL_LSB +: 2];
                watchdogCode <= writedata[WATCHDOG_CODE_LSB +: 4];
            end
        end
    end

    // ------------------------------------------------------------
    // prescale dividers
    // ------------------------------------------------------------
    logic [PRESCALE_WIDTH-1:0] cpuDiv;
    logic [PRESCALE_WIDTH-1:0] timerDiv;

    // cpu divider is not covered by the clear bit
    prescale_counter #(.WIDTH(PRESCALE_WIDTH)) cpuPrescale (
        .clock (clock),
        .rst_n (rst_n),
        .clear (1'b0),
        .count (cpuDiv)
    );

    // shared divider for basic timer and timer/counters
    prescale_counter #(.WIDTH(PRESCALE_WIDTH)) timerPrescale (
        .clock (clock),
        .rst_n (rst_n),
        .clear (clearDivider), // R2
        .count (timerDiv)
    );

    // enable when the low bits of the divider are all ones
    function automatic logic lowOnes(input logic [PRESCALE_WIDTH-1:0] v, input int n);
        logic [PRESCALE_WIDTH-1:0] m;
        m = PRESCALE_WIDTH'((1 << n) - 1);
        return (v & m) == m;
    endfunction

    // ------------------------------------------------------------
    // rate selection
    // ------------------------------------------------------------
    always_comb begin
        case (cpuSelect) // R4
            CPU_DIV16: cpuClockEnable = lowOnes(cpuDiv, 4);
            CPU_DIV8:  cpuClockEnable = lowOnes(cpuDiv, 3);
            CPU_DIV2:  cpuClockEnable = lowOnes(cpuDiv, 1);
            default:   cpuClockEnable = 1'b1;
        endcase
    end

    always_comb begin
        case (timerSelect) // R6
            BT_DIV4096: timerClockEnable = lowOnes(timerDiv, 12);
            BT_DIV1024: timerClockEnable = lowOnes(timerDiv, 10);
            BT_DIV128:  timerClockEnable = lowOnes(timerDiv, 7);
            default:    timerClockEnable = lowOnes(timerDiv, 4);
        endcase
    end

    assign counterTick = timerClockEnable & ~clearDivider;

    // ------------------------------------------------------------
    // basic timer count
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            basicTimerCount <= 8'h00;
        end else if (clearCounter) begin
            basicTimerCount <= 8'h00; // R1
        end else if (counterTick) begin
            basicTimerCount <= basicTimerCount + 8'h01;
        end
    end
endmodule

// ---- sim/clock_divider_control_asserts.sv ----
`timescale 1ns/1ps
module clock_divider_control_asserts
    import clock_divider_control_pkg::*;
(
    // bus and state
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        cpuClockEnable,
    input wire logic        timerClockEnable,
    input wire logic [7:0]  basicTimerCount,
    input wire logic [1:0]  cpuSelect
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // accepted timer control write with bit b set
    sequence tcWr(b);
        write && !waitrequest && address == BASIC_TIMER_CONTROL_OFFSET && writedata[b];
    endsequence
    a_count_clear: assert property (tcWr(1) |=> basicTimerCount == 8'h00)
        else $error("count kept");
    a_div_clear: assert property (tcWr(0) |-> ##2 !timerClockEnable [*8])
        else $error("divider kept");
    a_div16_gap: assert property (cpuClockEnable && cpuSelect == CPU_DIV16
        ##1 (cpuSelect == CPU_DIV16) [*8] |-> !cpuClockEnable) else $error("div16");
    a_div8_gap: assert property (cpuClockEnable && cpuSelect == CPU_DIV8
        ##1 $stable(cpuSelect) [*8] |-> cpuClockEnable) else $error("div8");
    a_div1_run: assert property (cpuSelect == CPU_DIV1 [*2] |-> cpuClockEnable)
        else $error("div1");
    a_clear_reads: assert property (read && !waitrequest
        && address == BASIC_TIMER_CONTROL_OFFSET
        |-> readdata[1:0] == 2'h0) else $error("clear bit reads one");
endmodule
bind clock_divider_control clock_divider_control_asserts u_check (.*);

// ---- sim/clock_divider_control_test.sv ----
`timescale 1ns/1ps
module clock_divider_control_test import clock_divider_control_pkg::*;;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata, rdat, readSeen;
    logic        waitSeen, counterTick, wakeDisable;
    logic [3:0]  watchdogCode;
    int          nt;
    logic        waitrequest, cpuClockEnable, timerClockEnable;
    logic [7:0]  basicTimerCount;
    logic [1:0]  cpuSelect;
    int          errors = 0, n_tests = 0, k;
    int          cs[4] = '{4, 3, 1, 0};
    int          ts[4] = '{12, 10, 7, 4};
    clock_divider_control u_dut (.*);
    initial forever #20 clock = ~clock;
    // bus answer as it stands at the coming rising edge
    always @(negedge clock) begin
        waitSeen = waitrequest;
        readSeen = readdata;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus access, held until waitrequest is seen low
    task automatic xfer(input bit rw, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        writedata <= {24'h00_0000, d};
        write <= rw;
        read <= !rw;
        do @(posedge clock); while (waitSeen !== 1'b0);
        rdat = readSeen;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    // count enable pulses over n cycles
    task automatic cnt(input int n, input bit cpu);
        k = 0;
        nt = 0;
        repeat (n) begin
            @(negedge clock);
            k += cpu ? cpuClockEnable : timerClockEnable;
            nt += counterTick;
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        xfer(0, 8'hD4, 8'h00);
        chk(rdat, 32'h0000_0000);
        cnt(64, 1);
        chk(k, 4);
        $display("reset test done");
        for (int c = 0; c < 4; c++) begin
            xfer(1, 8'hD4, 8'(c << 3));
            cnt(64, 1);
            chk(k, 64 >> cs[c]);
            xfer(0, 8'hD4, 8'h00);
            chk(rdat, 32'(c << 3));
            xfer(1, 8'hD3, 8'(c << 2));
            cnt(4096, 0);
            chk(k, 4096 >> ts[c]);
            chk(nt, k);
        end
        $display("select test done");
        xfer(1, 8'hD3, 8'h0E);
        @(negedge clock);
        chk(basicTimerCount, 8'h00);
        xfer(0, 8'hD3, 8'h00);
        chk(rdat, 32'h0000_000C);
        repeat (40) @(posedge clock);
        k = basicTimerCount;
        xfer(1, 8'hD3, 8'h0C);
        chk(basicTimerCount >= k, 1);
        $display("counter clear test done");
        xfer(1, 8'hD3, 8'h0D);
        @(posedge clock);
        cnt(12, 0);
        chk(k, 0);
        $display("divider clear test done");
        xfer(1, 8'hD4, 8'h98);
        xfer(1, 8'hD3, 8'hAC);
        @(negedge clock);
        chk({wakeDisable, cpuSelect}, 3'b111);
        chk(watchdogCode, 4'hA);
        xfer(0, 8'hD3, 8'h00);
        chk(rdat, 32'h0000_00AC);
        $display("field test done");
        xfer(1, 8'hD5, 8'hFF);
        xfer(0, 8'hD5, 8'h00);
        chk(rdat, 32'h0000_0000);
        xfer(0, 8'hD4, 8'h00);
        chk(rdat, 32'h0000_0098);
        $display("unmapped test done");
        wrap_up;
    end
    // watchdog against a hung handshake
    initial begin
        #2_000_000;
        errors++;
        wrap_up;
    end
endmodule
